/* dv/wide_memory_seq_handshake_test.sv */
`timescale 1ns/100ps
module wide_memory_seq_handshake_test;
  import wwm_pkg::*;
  localparam int REF_SIM = 40;
  logic              clk, nrst, psel, penable, pwrite, pready, pslverr;
  logic [11:0]       paddr;
  logic [31:0]       pwdata, prdata, rd32;
  logic              err;
  logic              addr_available_n, addr_acknowledge_n, data_request_n, data_acknowledge_n;
  logic [ADDR_W-1:0] addr_in;
  logic [MODE_W-1:0] mode;
  logic [BSEL_W-1:0] byte_sel;
  logic              seq_descend, seq_halt, refresh_gate;
  logic [WORD_W-1:0] wdata, rdata;
  logic [WORD_W-1:0] mem_m [WORDS];
  int                mismatches, tests_run;

  wwm_ctrl #(.REF_ROW_CYCLES(REF_SIM)) DUT (.*);
  wwm_req_model rq (.*);

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // ----------------------------------------
  // checking and bus tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [WORD_W-1:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : report_and_stop

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // answer and data are taken at the edge that sees pready high
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd32    = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  function automatic logic [WORD_W-1:0] merge(input logic [WORD_W-1:0] o, n, input int s, l);
    merge = o;
    for (int i = s; i < s + l && i < BYTES; i++) merge[i*8 +: 8] = n[i*8 +: 8];
  endfunction : merge

  function automatic logic [WORD_W-1:0] rnd();
    return {$urandom, $urandom, $urandom, $urandom};
  endfunction : rnd

  // one non-sequential cycle; read-modify-write reads first, then writes
  task automatic op(input logic [3:0] m, a, input logic [9:0] bs, input logic [WORD_W-1:0] wd);
    logic [WORD_W-1:0] rd;
    int                n;
    rq.addr_hs(a, m, bs, 1'b0, n);
    if (!(m inside {MODE_WW_WR, MODE_BYTE_WR})) begin
      rq.data_hs(1'b0, wd, rd, n);
      chk("rdata", rd, mem_m[a]);
      chk("word time", 128'(n > XFER_CYC), 128'(1));
    end
    if (m inside {MODE_WW_WR, MODE_BYTE_WR, MODE_RMW_B, MODE_RMW_WW}) begin
      rq.data_hs(1'b1, wd, rd, n);
      case (m)
        MODE_BYTE_WR: mem_m[a] = merge(mem_m[a], wd, bs[3:0], bs[7:4] + 1);
        MODE_RMW_B:   mem_m[a] = merge(mem_m[a], wd, bs[3:0], 1);
        default:      mem_m[a] = wd;
      endcase
    end
  endtask : op

  task automatic seq(input logic [3:0] m, a, input logic dn, input int cnt);
    logic [WORD_W-1:0] rd, wd;
    int                n;
    rq.addr_hs(a, m, 10'h000, dn, n);
    chk("sync time", 128'(n > SYNC_CYC), 128'(1));
    for (int i = 0; i < cnt; i++) begin
      wd = rnd();
      rq.data_hs(m == MODE_SEQ_WR, wd, rd, n);
      if (m == MODE_SEQ_WR) mem_m[a] = wd;
      else chk("seq rdata", rd, mem_m[a]);
      chk("seq word time", 128'(n > XFER_CYC), 128'(1));
      chk("line rate", 128'((n + 2) * LINE_WRDS <= LINE_US * 1000 / CLK_NS), 128'(1));
      a = dn ? a - 4'h1 : a + 4'h1;
    end
    rq.pulse(1'b1);
    // a new address is only taken once the halt phase has run out
    rq.addr_hs(a, MODE_WW_RD, 10'h000, 1'b0, n);
    chk("halt time", 128'(n > HALT_CYC - 4), 128'(1));
    rq.data_hs(1'b0, '0, rd, n);
    chk("after halt", rd, mem_m[a]);
  endtask : seq

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    nrst    = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = '0;
    pwdata  = '0;
    mismatches = 0;
    tests_run  = 0;
    void'($urandom(32'haba215a7));
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    @(negedge clk);
    chk("acks idle", {addr_acknowledge_n, data_acknowledge_n}, 128'h3);
    chk("rdata reset", rdata, '0);
    apb(1'b0, OFS_CTRL, 32'h0);
    chk("ctrl reset", rd32, CTRL_RST);
    apb(1'b0, 12'h010, 32'h0);
    chk("unmapped", {err, rd32}, {1'b1, 32'h0});
    apb(1'b1, OFS_CTRL, 32'h1);
    apb(1'b0, OFS_CTRL, 32'h0);
    chk("ctrl ext", rd32, 32'h1);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk("status idle", rd32, 32'(ST_IDLE));
    for (int a = 0; a < WORDS; a++) op(MODE_WW_WR, 4'(a), 10'h000, rnd());
    rq.pulse(1'b0);
    for (int i = 0; i < 16; i++) op(MODE_WW_RD, 4'($urandom % WORDS), 10'h000, rnd());
    // one external gate so far: one refresh of row zero
    apb(1'b0, OFS_REFCNT, 32'h0);
    chk("refresh count", rd32, 32'h0001_0001);
    apb(1'b1, OFS_CTRL, 32'h0);
    for (int b = 0; b < RMWB_VARS; b++) op(MODE_RMW_B, 4'h5, 10'(b), rnd());
    op(MODE_BYTE_WR, 4'h6, 10'h033, rnd());
    op(MODE_BYTE_WR, 4'h6, 10'h0FE, rnd());
    op(MODE_RMW_WW, 4'h7, 10'h000, rnd());
    op(4'hF, 4'h7, 10'h000, rnd());
    op(MODE_WW_RD, 4'h5, 10'h000, '0);
    op(MODE_WW_RD, 4'h6, 10'h000, '0);
    apb(1'b0, OFS_ADDR, 32'h0);
    chk("addr reg", rd32, {24'h000000, MODE_WW_RD, 4'h6});
    seq(MODE_SEQ_RD, 4'hE, 1'b0, 4);
    seq(MODE_SEQ_RD, 4'h1, 1'b1, 3);
    seq(MODE_SEQ_WR, 4'h9, 1'b0, 3);
    seq(MODE_SEQ_RD, 4'hB, 1'b1, 3);
    report_and_stop();
  end

  // bench needs a few thousand cycles; this leaves ample margin
  initial begin
    repeat (30000) @(posedge clk);
    mismatches++;
    report_and_stop();
  end
endmodule : wide_memory_seq_handshake_test

/* dv/wwm_req_model.sv */
`timescale 1ns/100ps
module wwm_req_model
  import wwm_pkg::*;
(
  input  wire logic              clk,
  output logic                   addr_available_n,
  input  wire logic              addr_acknowledge_n,
  output logic                   data_request_n,
  input  wire logic              data_acknowledge_n,
  output logic      [ADDR_W-1:0] addr_in,
  output logic      [MODE_W-1:0] mode,
  output logic      [BSEL_W-1:0] byte_sel,
  output logic                   seq_descend,
  output logic                   seq_halt,
  output logic                   refresh_gate,
  output logic      [WORD_W-1:0] wdata,
  input  wire logic [WORD_W-1:0] rdata
);
  initial begin
    addr_available_n = 1'b1;
    data_request_n   = 1'b1;
    addr_in          = '0;
    mode             = '0;
    byte_sel         = '0;
    seq_descend      = 1'b0;
    seq_halt         = 1'b0;
    refresh_gate     = 1'b0;
    wdata            = '0;
  end

  // acks are sampled at the rising edge; only the bench watchdog ends a wait
  task automatic wait_ack(input bit dat, input logic lvl, output int n);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while ((dat ? data_acknowledge_n : addr_acknowledge_n) !== lvl);
  endtask : wait_ack

  task automatic addr_hs(input logic [3:0] a, m, input logic [9:0] bs, input logic dn,
                         output int n);
    int k;
    @(posedge clk);
    addr_in          <= a;
    mode             <= m;
    byte_sel         <= bs;
    seq_descend      <= dn;
    addr_available_n <= 1'b0;
    wait_ack(1'b0, 1'b0, n);
    addr_available_n <= 1'b1;
    addr_in          <= ~a;
    wait_ack(1'b0, 1'b1, k);
  endtask : addr_hs

  task automatic data_hs(input logic wr, input logic [WORD_W-1:0] wd,
                         output logic [WORD_W-1:0] rd, output int n);
    int k;
    @(posedge clk);
    if (wr) begin
      wdata <= wd;
    end
    data_request_n <= 1'b0;
    wait_ack(1'b1, 1'b0, n);
    rd = rdata;
    data_request_n <= 1'b1;
    // released data lines must not keep showing the old word
    wdata          <= ~wd;
    wait_ack(1'b1, 1'b1, k);
  endtask : data_hs

  task automatic pulse(input bit hlt);
    @(posedge clk);
    if (hlt) seq_halt <= 1'b1;
    else refresh_gate <= 1'b1;
    repeat (2) @(posedge clk);
    seq_halt     <= 1'b0;
    refresh_gate <= 1'b0;
  endtask : pulse
endmodule : wwm_req_model

/* verilog/wwm_ctrl.sv */
// Functional notes
// R1: requester supplies a new address for every non-sequential cycle.
// R2: sequential modes move whole words from one start address, addresses generated here.
// R3: sequential cycle is 400 ns sync, variable data phase, 400 ns halt.
// R4: sync latches start address, direction and read/write selection.
// R5: sequential data phase runs until halt; each word takes at least 100 ns.
// R6: four mode lines and ten byte-select lines pick one of 84 modes.
// R7: byte read-modify-write has 16 variants chosen by byte select code.
// R8: requester holds address-available until address-acknowledge arrives.
// R9: requester drops available on ack; controller then drops ack.
// R10: read: on data-request fetch word, drive bus, then assert data-acknowledge.
// R11: requester captures data at data-acknowledge, then withdraws data-request.
// R12: data-acknowledge is withdrawn once data-request is withdrawn.
// R13: sequential read repeats data-request without a new address handshake.
// R14: write: requester drives data and request; memory stores and acknowledges.
// R15: every row refreshed at least once per refresh interval.
// R16: internal or external refresh chosen by configuration; internal may stall.
// R17: with external refresh the requester gates refresh inside blanking.
// R18: interface sustains 120 words per 31 us line.
// R19: each location holds one 128-bit word; single transfers of 1 to 16 bytes.
// R20: byte read-modify-write alters only selected bytes.
// R21: sequential address steps by one word, up or down per sampled direction.
// R22: both acknowledges stay deasserted after reset until a request.
`timescale 1ns/100ps
module wwm_ctrl
  import wwm_pkg::*;
#(
  parameter int REF_ROW_CYCLES = REF_ROW_CYC
)(
  input  wire logic              clk,
  input  wire logic              nrst,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              addr_available_n,
  output logic                   addr_acknowledge_n,
  input  wire logic              data_request_n,
  output logic                   data_acknowledge_n,
  input  wire logic [ADDR_W-1:0] addr_in,
  input  wire logic [MODE_W-1:0] mode,
  input  wire logic [BSEL_W-1:0] byte_sel,
  input  wire logic              seq_descend,
  input  wire logic              seq_halt,
  input  wire logic              refresh_gate,
  input  wire logic [WORD_W-1:0] wdata,
  output logic      [WORD_W-1:0] rdata
);
  wwm_state_e        st_r;
  logic [15:0]       cnt_r;
  logic [ADDR_W-1:0] addr_r;
  logic [MODE_W-1:0] mode_r;
  logic [BSEL_W-1:0] bsel_r;
  logic              dir_r;
  logic              wr_phase_r;
  logic [31:0]       ctrl_r;
  logic [23:0]       ref_tmr_r;
  logic              ref_pend_r;
  logic              gate_d_r;
  logic [ADDR_W-1:0] ref_row_r;
  logic [15:0]       ref_cnt_r;
  logic              seq;
  logic              read_modify_write;
  logic              is_wr;
  logic              xfer_done;
  logic              mem_we;
  logic [BYTES-1:0]  mem_be;
  logic [WORD_W-1:0] mem_rd;
  logic              ref_tick;
  logic              apb_acc;

  // ----------------------------------------
  // mode decode
  // ----------------------------------------
  function automatic logic [BYTES-1:0] byte_run(input logic [3:0] start,
                                                 input logic [3:0] len);
    logic [4:0] last;
    byte_run = '0;
    last = 5'(start) + 5'(len);
    for (int i = 0; i < BYTES; i++) begin
      if (5'(i) >= 5'(start) && 5'(i) <= last) byte_run[i] = 1'b1;
    end
  endfunction : byte_run

  function automatic logic is_seq(input logic [MODE_W-1:0] m);
    is_seq = (m == MODE_SEQ_RD) || (m == MODE_SEQ_WR);
  endfunction : is_seq

  assign seq = is_seq(mode_r); // R2
  assign read_modify_write = (mode_r == MODE_RMW_B) || (mode_r == MODE_RMW_WW);
  // rmw cycles read first, then write: only the selected byte for byte rmw, the whole new word for word rmw
  assign is_wr = (mode_r == MODE_WW_WR) || (mode_r == MODE_BYTE_WR) ||
                 (mode_r == MODE_SEQ_WR) || (read_modify_write && wr_phase_r); // R6
  // every word transfer holds for the minimum word time
  assign xfer_done = (st_r == ST_XFER) && (cnt_r == 16'(XFER_CYC - 1)); // R5 R18
  assign mem_we = xfer_done && is_wr; // R14

  always_comb begin
    case (mode_r)
      MODE_BYTE_WR: mem_be = byte_run(bsel_r[3:0], bsel_r[7:4]); // R19
      MODE_RMW_B:   mem_be = BYTES'(1) << bsel_r[3:0]; // R7 R20
      default:      mem_be = '1;
    endcase
  end

  wwm_mem u_mem (
    .clk     (clk),
    .we      (mem_we),
    .addr    (addr_r),
    .byte_en (mem_be),
    .wdata   (wdata),
    .rdata   (mem_rd)
  );

  // ----------------------------------------
  // handshake sequencer
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!nrst) begin
      st_r               <= ST_IDLE;
      cnt_r              <= 16'h0000;
      addr_r             <= '0;
      mode_r             <= '0;
      bsel_r             <= '0;
      dir_r              <= 1'b0;
      wr_phase_r         <= 1'b0;
      addr_acknowledge_n <= 1'b1; // R22
      data_acknowledge_n <= 1'b1; // R22
      rdata              <= '0;
    end else begin
      case (st_r)
        ST_IDLE: begin
          cnt_r      <= 16'h0000;
          wr_phase_r <= 1'b0;
          // refresh wins over a new cycle so a row is never starved
          if (ref_pend_r) begin
            st_r <= ST_REFRESH;
          end else if (!addr_available_n) begin
            addr_r <= addr_in; // R1
            mode_r <= mode;
            bsel_r <= byte_sel;
            dir_r  <= seq_descend;
            if (is_seq(mode)) begin
              st_r <= ST_SYNC; // R3
            end else begin
              addr_acknowledge_n <= 1'b0; // R8
              st_r               <= ST_ADDR_ACK;
            end
          end
        end
        ST_SYNC: begin
          cnt_r <= cnt_r + 16'h0001;
          dir_r <= seq_descend; // R4
          if (cnt_r == 16'(SYNC_CYC - 1)) begin
            addr_acknowledge_n <= 1'b0;
            st_r               <= ST_ADDR_ACK;
          end
        end
        ST_ADDR_ACK: begin
          cnt_r <= 16'h0000;
          if (addr_available_n) begin
            addr_acknowledge_n <= 1'b1; // R9
            st_r               <= ST_DATA_WAIT;
          end
        end
        ST_DATA_WAIT: begin
          cnt_r <= 16'h0000;
          if (!data_request_n) begin
            st_r <= ST_XFER;
          end else if (seq && seq_halt) begin
            st_r <= ST_HALT; // R5
          end
        end
        ST_XFER: begin
          cnt_r <= cnt_r + 16'h0001;
          if (xfer_done) begin
            if (!is_wr) rdata <= mem_rd; // R10
            data_acknowledge_n <= 1'b0;
            st_r               <= ST_DATA_ACK;
          end
        end
        ST_DATA_ACK: begin
          if (data_request_n) begin
            data_acknowledge_n <= 1'b1; // R12
            if (seq) begin
              addr_r <= dir_r ? addr_r - 1'b1 : addr_r + 1'b1; // R21
              st_r   <= ST_DATA_WAIT; // R13
            end else if (read_modify_write && !wr_phase_r) begin
              wr_phase_r <= 1'b1;
              st_r       <= ST_DATA_WAIT;
            end else begin
              st_r <= ST_IDLE;
            end
          end
        end
        ST_HALT: begin
          cnt_r <= cnt_r + 16'h0001;
          if (cnt_r == 16'(HALT_CYC - 1)) st_r <= ST_IDLE; // R3
        end
        ST_REFRESH: begin
          cnt_r <= cnt_r + 16'h0001;
          if (cnt_r == 16'(REF_BUSY_CYC - 1)) st_r <= ST_IDLE;
        end
        default: st_r <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // refresh timing
  // ----------------------------------------
  // external gates come from the requester, who places them in blanking
  assign ref_tick = ctrl_r[CTRL_EXT_BIT] ? (refresh_gate && !gate_d_r) // R16 R17
                                         : (ref_tmr_r == 24'(REF_ROW_CYCLES - 1));

  always_ff @(posedge clk) begin
    if (!nrst) begin
      ref_tmr_r <= 24'h000000;
      gate_d_r  <= 1'b0;
    end else begin
      gate_d_r  <= refresh_gate;
      ref_tmr_r <= (ref_tmr_r == 24'(REF_ROW_CYCLES - 1)) ? 24'h000000
                                                          : ref_tmr_r + 24'h000001; // R15
    end
  end

  // a tick in the same cycle as the take is kept pending
  always_ff @(posedge clk) begin
    if (!nrst) begin
      ref_pend_r <= 1'b0;
      ref_row_r  <= '0;
      ref_cnt_r  <= 16'h0000;
    end else begin
      ref_pend_r <= ref_tick || (ref_pend_r && !(st_r == ST_IDLE)); // R15
      if (st_r == ST_REFRESH && cnt_r == 16'(REF_BUSY_CYC - 1)) begin
        ref_row_r <= ref_row_r + 1'b1;
        ref_cnt_r <= ref_cnt_r + 16'h0001;
      end
    end
  end

  // ----------------------------------------
  // apb slave
  // ----------------------------------------
  // one wait state keeps prdata and pready straight from flops
  assign apb_acc = psel && penable && !pready;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      ctrl_r  <= CTRL_RST;
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= apb_acc;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
      if (apb_acc) begin
        case (paddr)
          OFS_CTRL: begin
            if (pwrite) ctrl_r <= {31'h0000_0000, pwdata[CTRL_EXT_BIT]}; // R16
            prdata <= ctrl_r;
          end
          OFS_STATUS: prdata <= {25'h0000000, ref_pend_r, wr_phase_r, dir_r, 1'b0, st_r};
          OFS_ADDR:   prdata <= {24'h000000, mode_r, addr_r};
          OFS_REFCNT: prdata <= {12'h000, ref_row_r, ref_cnt_r};
          default:    pslverr <= 1'b1;
        endcase
      end
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_ack_rest;
    @(posedge clk) disable iff (!nrst)
    (st_r == ST_IDLE) |-> addr_acknowledge_n && data_acknowledge_n;
  endproperty
  a_ack_rest: assert property (p_ack_rest) else $error("ack active while idle"); // R22

  property p_addr_ack_hold;
    @(posedge clk) disable iff (!nrst)
    !addr_acknowledge_n && !addr_available_n |=> !addr_acknowledge_n;
  endproperty
  a_addr_ack_hold: assert property (p_addr_ack_hold) else $error("address ack dropped early"); // R9

  property p_addr_ack_drop;
    @(posedge clk) disable iff (!nrst)
    !addr_acknowledge_n && addr_available_n |=> addr_acknowledge_n;
  endproperty
  a_addr_ack_drop: assert property (p_addr_ack_drop) else $error("address ack not dropped"); // R9

  property p_data_ack_drop;
    @(posedge clk) disable iff (!nrst)
    !data_acknowledge_n && data_request_n |=> data_acknowledge_n;
  endproperty
  a_data_ack_drop: assert property (p_data_ack_drop) else $error("data ack not dropped"); // R12

  property p_sync_len;
    @(posedge clk) disable iff (!nrst)
    $fell(st_r == ST_SYNC) |-> $past(cnt_r) == 16'(SYNC_CYC - 1) && !addr_acknowledge_n;
  endproperty
  a_sync_len: assert property (p_sync_len) else $error("sync phase length wrong"); // R3

  property p_halt_len;
    @(posedge clk) disable iff (!nrst)
    $rose(st_r == ST_HALT) |-> ##(HALT_CYC - 1) (st_r == ST_HALT) ##1 (st_r == ST_IDLE);
  endproperty
  a_halt_len: assert property (p_halt_len) else $error("halt phase length wrong"); // R3

  property p_word_min;
    @(posedge clk) disable iff (!nrst)
    $fell(data_acknowledge_n) |-> $past(cnt_r) == 16'(XFER_CYC - 1);
  endproperty
  a_word_min: assert property (p_word_min) else $error("word transfer too short"); // R5

  property p_seq_step;
    @(posedge clk) disable iff (!nrst)
    seq && $rose(data_acknowledge_n) |->
      addr_r == ($past(dir_r) ? $past(addr_r) - 1'b1 : $past(addr_r) + 1'b1);
  endproperty
  a_seq_step: assert property (p_seq_step) else $error("sequential address step wrong"); // R21

  property p_rmw_byte;
    @(posedge clk) disable iff (!nrst)
    mem_we && mode_r == MODE_RMW_B |-> $onehot(mem_be) && wr_phase_r;
  endproperty
  a_rmw_byte: assert property (p_rmw_byte) else $error("byte rmw touches wrong bytes"); // R20

  property p_read_data;
    @(posedge clk) disable iff (!nrst)
    $fell(data_acknowledge_n) && !is_wr |-> rdata == $past(mem_rd);
  endproperty
  a_read_data: assert property (p_read_data) else $error("read data not fetched"); // R10

  c_seq_read: cover property (@(posedge clk) disable iff (!nrst)
    $rose(st_r == ST_HALT) && mode_r == MODE_SEQ_RD);
  c_rmw_write: cover property (@(posedge clk) disable iff (!nrst)
    mem_we && mode_r == MODE_RMW_B);
  c_refresh: cover property (@(posedge clk) disable iff (!nrst)
    $rose(st_r == ST_REFRESH) && ctrl_r[CTRL_EXT_BIT]);
endmodule : wwm_ctrl

/* verilog/wwm_mem.sv */
`timescale 1ns/100ps
module wwm_mem
  import wwm_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              we,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [BYTES-1:0]  byte_en,
  input  wire logic [WORD_W-1:0] wdata,
  output logic      [WORD_W-1:0] rdata
);
  logic [WORD_W-1:0] mem_r [WORDS];

  // only enabled bytes change; the rest keep their old value
  always_ff @(posedge clk) begin
    if (we) begin
      for (int i = 0; i < BYTES; i++) begin
        if (byte_en[i]) begin
          mem_r[addr][i*8 +: 8] <= wdata[i*8 +: 8];
        end
      end
    end
  end

  assign rdata = mem_r[addr];
endmodule : wwm_mem

/* verilog/wwm_pkg.sv */
package wwm_pkg;
  // ----------------------------------------
  // word and control line widths
  // ----------------------------------------
  localparam int WORD_W    = 128;
  localparam int BYTES     = 16;
  localparam int ADDR_W    = 4;
  localparam int WORDS     = 16;
  localparam int MODE_W    = 4;
  localparam int BSEL_W    = 10;
  localparam int MODE_CNT  = 84;
  localparam int RMWB_VARS = 16;
  localparam int LINE_US   = 31;
  localparam int LINE_WRDS = 120;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_NS     = 8;
  localparam int SYNC_NS    = 400;
  localparam int HALT_NS    = 400;
  localparam int XFER_NS    = 100;
  localparam int REF_MS     = 2;
  localparam int STALL_US   = 1400;
  localparam int SYNC_CYC   = (SYNC_NS + CLK_NS - 1) / CLK_NS;
  localparam int HALT_CYC   = (HALT_NS + CLK_NS - 1) / CLK_NS;
  localparam int XFER_CYC   = (XFER_NS + CLK_NS - 1) / CLK_NS;
  localparam int REF_ROW_CYC = REF_MS * 1000000 / CLK_NS / WORDS;
  localparam int REF_BUSY_CYC = 8;
  // ----------------------------------------
  // mode codes
  // ----------------------------------------
  localparam logic [3:0] MODE_WW_RD   = 4'h0;
  localparam logic [3:0] MODE_WW_WR   = 4'h1;
  localparam logic [3:0] MODE_BYTE_WR = 4'h2;
  localparam logic [3:0] MODE_RMW_B   = 4'h3;
  localparam logic [3:0] MODE_RMW_WW  = 4'h4;
  localparam logic [3:0] MODE_SEQ_RD  = 4'h5;
  localparam logic [3:0] MODE_SEQ_WR  = 4'h6;
  // ----------------------------------------
  // registers
  // ----------------------------------------
  localparam logic [11:0] OFS_CTRL   = 12'h000;
  localparam logic [11:0] OFS_STATUS = 12'h004;
  localparam logic [11:0] OFS_ADDR   = 12'h008;
  localparam logic [11:0] OFS_REFCNT = 12'h00C;
  localparam int CTRL_EXT_BIT = 0;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;

  typedef enum logic [2:0] {
    ST_IDLE, ST_SYNC, ST_ADDR_ACK, ST_DATA_WAIT, ST_XFER, ST_DATA_ACK, ST_HALT, ST_REFRESH
  } wwm_state_e;
endpackage : wwm_pkg
